// ==== rtl/qds_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
module qds_fifo #(
  parameter int W = 16,  // word width
  parameter int D = 4    // depth in words
) (
  input  wire logic         clk,        // system clock
  input  wire logic         rst_n,      // synchronous reset, active low
  input  wire logic         flush,      // drop all words
  input  wire logic         in_valid,   // word offered
  output logic              in_ready,   // room for a word
  input  wire logic [W-1:0] in_data,    // offered word
  output logic              out_valid,  // word available
  input  wire logic         out_ready,  // drain accepts
  output logic      [W-1:0] out_data    // oldest word
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready  = (cnt_r != CW'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  // pointers wrap explicitly so any depth works, not only powers of two
  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end else begin
      if (push)
        wp_nxt = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      if (push && !pop)
        cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push)
        cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; words are only read when counted
  always_ff @(posedge clk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

endmodule // qds_fifo

// ==== rtl/qds_pkg.sv ====
// constants shared by the quad converter serial load block
package qds_pkg;

  // ****************************************************************
  // word format and channel registers
  // ****************************************************************
  localparam int WORD_W    = 16;  // serial command width
  localparam int CODE_W    = 14;  // channel code width
  localparam int NUM_CH    = 4;   // number of channels
  localparam int CHAIN_DLY = 17;  // sclk pulses from serial_in to chain_out
  localparam int SEL_HI    = 15;  // channel_sel_hi position in the word
  localparam int SEL_LO    = 14;  // channel_sel_lo position in the word
  localparam int FIFO_DEP  = 4;   // words buffered between capture and load

  // ****************************************************************
  // reset and preset values
  // ****************************************************************
  localparam logic [CODE_W-1:0] HALF_SCALE = 14'h2000;
  localparam logic [CODE_W-1:0] ZERO_CODE  = 14'h0000;
  localparam logic [1:0]        POR_CYCLES = 2'h3;

  // ****************************************************************
  // pin synchroniser bit positions and idle levels
  // ****************************************************************
  localparam int PIN_W      = 6;
  localparam int PIN_PRESET = 5;
  localparam int PIN_LEVEL  = 4;
  localparam int PIN_CS     = 3;
  localparam int PIN_SCLK   = 2;
  localparam int PIN_SIN    = 1;
  localparam int PIN_UPD    = 0;
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h29;

endpackage : qds_pkg

// ==== rtl/qds_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pins
module qds_sync #(
  parameter int               W    = 1,   // number of pins
  parameter logic [W-1:0]     INIT = '0   // idle level held in reset
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] d,      // raw pin levels
  output logic      [W-1:0] q       // synchronised levels
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // first stage is read only by the second stage
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q_r    <= INIT;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule // qds_sync

// ==== rtl/qds_top.sv ====
// serial load front end of a quad 14-bit converter
// Function
// - preset forces input and output registers
// - level high gives 2000h, low gives zero
// - power-on loads the same level-selected code
// - select high freezes the shift register
// - select rising copies word to input register
// - update strobe ignores select state
// - serial_in sampled on sclk rising, select low
// - chain_out repeats serial_in 17 pulses later
// - update low copies all four input registers
// - update acts without any sclk edge
// - 16-bit words, msb first, select held low
// - only last 16 bits are used
// - two select bits choose the channel
module qds_top
  import qds_pkg::*;
(
  input  wire logic              clk,             // 50 MHz system clock
  input  wire logic              rst_n,           // sync reset, active low
  input  wire logic              preset_n,        // preset pin, active low
  input  wire logic              preset_level,    // 1: half-scale, 0: zero
  input  wire logic              chip_sel_n,      // select pin, active low
  input  wire logic              sclk,            // serial clock pin
  input  wire logic              serial_in,       // serial data pin
  input  wire logic              output_update_n, // update strobe, active low
  output logic                   chain_out,       // daisy chain data
  output logic                   word_ready,      // capture buffer has room
  output logic      [CODE_W-1:0] chan0_code,      // channel 0 output reg
  output logic      [CODE_W-1:0] chan1_code,      // channel 1 output reg
  output logic      [CODE_W-1:0] chan2_code,      // channel 2 output reg
  output logic      [CODE_W-1:0] chan3_code       // channel 3 output reg
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [PIN_W-1:0] pins_s;
  logic             preset_n_s, level_s, cs_n_s, sclk_s, sin_s, upd_n_s;

  qds_sync #(
    .W    (PIN_W),
    .INIT (PIN_IDLE)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({preset_n, preset_level, chip_sel_n, sclk, serial_in,
             output_update_n}),
    .q     (pins_s)
  );

  assign preset_n_s = pins_s[PIN_PRESET];
  assign level_s    = pins_s[PIN_LEVEL];
  assign cs_n_s     = pins_s[PIN_CS];
  assign sclk_s     = pins_s[PIN_SCLK];
  assign sin_s      = pins_s[PIN_SIN];
  assign upd_n_s    = pins_s[PIN_UPD];

  // channel field of a command word
  function automatic logic [1:0] chan_of(input logic [WORD_W-1:0] w);
    chan_of = {w[SEL_HI], w[SEL_LO]};
  endfunction

  // ****************************************************************
  // power-on and preset control
  // ****************************************************************
  logic [1:0]        por_cnt_r, por_cnt_nxt;
  logic              por_act, preset_act, upd_act;
  logic [CODE_W-1:0] preset_code;

  // power-on spans the synchroniser delay so the real level is seen
  always_comb begin
    por_cnt_nxt = por_cnt_r;
    if (por_cnt_r != 2'h0)
      por_cnt_nxt = por_cnt_r - 2'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      por_cnt_r <= POR_CYCLES;
    else
      por_cnt_r <= por_cnt_nxt;
  end

  assign por_act     = (por_cnt_r != 2'h0);
  assign preset_act  = por_act | ~preset_n_s;
  assign preset_code = level_s ? HALF_SCALE : ZERO_CODE;
  assign upd_act     = ~upd_n_s;

  // ****************************************************************
  // shift register and select edges
  // ****************************************************************
  logic [CHAIN_DLY-1:0] shift_r, shift_nxt;
  logic                 sclk_d_r, sclk_d_nxt;
  logic                 cs_d_r, cs_d_nxt;
  logic                 shift_ev, cs_rise;

  // sclk edges are found on the system clock; sclk must stay slow
  assign shift_ev = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign cs_rise  = cs_n_s & ~cs_d_r;

  // 17 stages: the top one feeds the chain output
  always_comb begin
    sclk_d_nxt = sclk_s;
    cs_d_nxt   = cs_n_s;
    shift_nxt  = shift_r;
    if (shift_ev)
      shift_nxt = {shift_r[CHAIN_DLY-2:0], sin_s};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r  <= '0;
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      shift_r  <= shift_nxt;
      sclk_d_r <= sclk_d_nxt;
      cs_d_r   <= cs_d_nxt;
    end
  end

  assign chain_out = shift_r[CHAIN_DLY-1];

  // ****************************************************************
  // captured word waiting for the buffer
  // ****************************************************************
  logic              pend_vld_r, pend_vld_nxt;
  logic [WORD_W-1:0] pend_word_r, pend_word_nxt;
  logic              fifo_in_ready, fifo_out_valid, drain_ready;
  logic [WORD_W-1:0] fifo_out_data;

  // a new capture wins over acceptance of the old one in the same cycle
  always_comb begin
    pend_vld_nxt  = pend_vld_r;
    pend_word_nxt = pend_word_r;
    if (preset_act) begin
      pend_vld_nxt = 1'b0;
    end else if (cs_rise) begin
      pend_vld_nxt  = 1'b1;
      pend_word_nxt = shift_r[WORD_W-1:0];
    end else if (fifo_in_ready) begin
      pend_vld_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_vld_r  <= 1'b0;
      pend_word_r <= '0;
    end else begin
      pend_vld_r  <= pend_vld_nxt;
      pend_word_r <= pend_word_nxt;
    end
  end

  // drain halts during preset; the flush drops stale words
  assign drain_ready = ~preset_act;

  qds_fifo #(
    .W (WORD_W),
    .D (FIFO_DEP)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (preset_act),
    .in_valid  (pend_vld_r),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_r),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out_data)
  );

  assign word_ready = fifo_in_ready;

  // ****************************************************************
  // input and output registers of the four channels
  // ****************************************************************
  logic [CODE_W-1:0] in_r  [NUM_CH];
  logic [CODE_W-1:0] in_nxt[NUM_CH];
  logic [CODE_W-1:0] out_r [NUM_CH];
  logic [CODE_W-1:0] out_nxt[NUM_CH];
  logic              load_ev;

  assign load_ev = fifo_out_valid & drain_ready;

  // preset first, then serial load and update strobe independently
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      in_nxt[i]  = in_r[i];
      out_nxt[i] = out_r[i];
      if (preset_act) begin
        in_nxt[i]  = preset_code;
        out_nxt[i] = preset_code;
      end else begin
        if (load_ev && chan_of(fifo_out_data) == 2'(i))
          in_nxt[i] = fifo_out_data[CODE_W-1:0];
        if (upd_act)
          out_nxt[i] = in_r[i];
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          in_r[g]  <= ZERO_CODE;
          out_r[g] <= ZERO_CODE;
        end else begin
          in_r[g]  <= in_nxt[g];
          out_r[g] <= out_nxt[g];
        end
      end
    end
  endgenerate

  assign chan0_code = out_r[0];
  assign chan1_code = out_r[1];
  assign chan2_code = out_r[2];
  assign chan3_code = out_r[3];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_preset_outputs: assert property (
    preset_act |=> (out_r[0] == $past(preset_code)) &&
                   (out_r[3] == $past(preset_code)))
    else $error("preset did not force output registers");

  a_half_scale: assert property (
    (preset_act && level_s) |=> (in_r[1] == 14'h2000))
    else $error("half-scale preset code wrong");

  a_zero_scale: assert property (
    (preset_act && !level_s) |=> (in_r[2] == 14'h0000))
    else $error("zero-scale preset code wrong");

  a_power_on: assert property (
    $rose(rst_n) |-> por_act [*3] ##1 !por_act)
    else $error("power-on preset window wrong");

  a_cs_freeze: assert property (
    cs_n_s |=> $stable(shift_r))
    else $error("shift register moved while deselected");

  a_cs_capture: assert property (
    (cs_rise && !preset_act) |=>
      pend_vld_r && (pend_word_r == $past(shift_r[WORD_W-1:0])))
    else $error("select rise did not capture last word");

  a_shift_in: assert property (
    shift_ev |=> (shift_r[0] == $past(sin_s)) &&
                 (shift_r[CHAIN_DLY-1] == $past(shift_r[CHAIN_DLY-2])))
    else $error("serial bit not shifted msb first");

  a_chain_delay: assert property (
    shift_ev |=> (chain_out == $past(shift_r[WORD_W-1])))
    else $error("chain output delay wrong");

  a_update_copy: assert property (
    (upd_act && !preset_act) |=>
      (out_r[0] == $past(in_r[0])) && (out_r[1] == $past(in_r[1])) &&
      (out_r[2] == $past(in_r[2])) && (out_r[3] == $past(in_r[3])))
    else $error("update did not copy all channels");

  a_update_hold: assert property (
    (!upd_act && !preset_act) |=> $stable(out_r[2]))
    else $error("output register moved without update");

  a_chan_decode: assert property (
    load_ev |=> (in_r[chan_of($past(fifo_out_data))] ==
                 $past(fifo_out_data[CODE_W-1:0])))
    else $error("word loaded into wrong channel");

  a_preset_prio: assert property (
    (preset_act && upd_act) |=> (out_r[1] == $past(preset_code)))
    else $error("update overrode preset");

  // inputs must follow the preset too, or a later strobe undoes it
  a_preset_inputs: assert property (
    preset_act |=> (in_r[0] == $past(preset_code)) &&
                   (in_r[3] == $past(preset_code)))
    else $error("preset did not force input registers");

  // a word caught mid-preset must never reach a channel afterwards
  a_preset_drop: assert property (
    preset_act |=> !pend_vld_r && !fifo_out_valid)
    else $error("word kept during preset");

  c_capture: cover property (cs_rise && !preset_act);
  c_sel_strobe: cover property (upd_act && !cs_n_s && !preset_act);
  c_load: cover property (load_ev ##[1:20] upd_act);
  c_half_scale: cover property (!preset_n_s && level_s);
  c_buffer_full: cover property (pend_vld_r && !fifo_in_ready);

endmodule // qds_top

// ==== sim/qds_host.sv ====
// serial master model that drives the block's three-wire link
module qds_host (
  input  wire logic clk,        // system clock
  input  wire logic chain_out,  // daisy chain data from the block
  output logic      chip_sel_n, // select, active low
  output logic      sclk,       // serial clock, still between shift calls
  output logic      serial_in   // serial data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic bits_q[$];  // bits shifted by the last shift call
  logic seen_q[$];  // chain_out before each pulse and after the last

  // idle link: deselected, clock low
  initial begin
    chip_sel_n = 1'b1;
    sclk       = 1'b0;
    serial_in  = 1'b0;
  end

  // select stays low for the whole word, also between bytes
  task automatic open_frame();
    @(negedge clk);
    chip_sel_n = 1'b0;
  endtask

  // msb first; data set while sclk low, sclk 4 clk low and 4 clk high
  task automatic shift(input logic [63:0] w, input int n);
    bits_q.delete();
    seen_q.delete();
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk);
      serial_in = w[i];
      bits_q.push_back(w[i]);
      repeat (3) @(negedge clk);
      seen_q.push_back(chain_out);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    seen_q.push_back(chain_out);
  endtask

  // released data line flips so a stale bit is never mistaken for data
  task automatic close_frame();
    @(negedge clk);
    chip_sel_n = 1'b1;
    serial_in  = ~serial_in;
    repeat (8) @(negedge clk);
  endtask
endmodule  // qds_host

// ==== sim/qds_top_tb.sv ====
// self-checking bench for the quad converter serial load block
module qds_top_tb
  import qds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // signals and expected register images
  // ****************************************************************
  logic              clk;
  logic              rst_n;
  logic              preset_n;
  logic              preset_level;
  logic              output_update_n;
  logic              chip_sel_n;
  logic              sclk;
  logic              serial_in;
  logic              chain_out;
  logic              word_ready;
  logic [CODE_W-1:0] code_o  [NUM_CH];  // channel output codes
  logic [CODE_W-1:0] in_exp  [NUM_CH];  // expected input registers
  logic [CODE_W-1:0] out_exp [NUM_CH];  // expected output registers
  int                fails;
  int                n_checks;

  qds_top qds_top_i (
    .clk             (clk),
    .rst_n           (rst_n),
    .preset_n        (preset_n),
    .preset_level    (preset_level),
    .chip_sel_n      (chip_sel_n),
    .sclk            (sclk),
    .serial_in       (serial_in),
    .output_update_n (output_update_n),
    .chain_out       (chain_out),
    .word_ready      (word_ready),
    .chan0_code      (code_o[0]),
    .chan1_code      (code_o[1]),
    .chan2_code      (code_o[2]),
    .chan3_code      (code_o[3])
  );

  qds_host qds_host_i (
    .clk        (clk),
    .chain_out  (chain_out),
    .chip_sel_n (chip_sel_n),
    .sclk       (sclk),
    .serial_in  (serial_in)
  );

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [CODE_W-1:0] seen, exp,
                       input string msg);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  task automatic chk_chans(input string msg);
    for (int i = 0; i < NUM_CH; i++) begin
      check(code_o[i], out_exp[i], msg);
    end
  endtask

  task automatic send(input logic [1:0] ch, input logic [CODE_W-1:0] c);
    qds_host_i.open_frame();
    qds_host_i.shift(64'({ch, c}), WORD_W);
    qds_host_i.close_frame();
    in_exp[ch] = c;
  endtask

  // strobe held long enough to pass the pin synchroniser
  task automatic update();
    @(negedge clk);
    output_update_n = 1'b0;
    repeat (6) @(negedge clk);
    output_update_n = 1'b1;
    out_exp = in_exp;
    repeat (4) @(negedge clk);
  endtask

  task automatic set_all(input logic [CODE_W-1:0] c);
    foreach (in_exp[i]) begin
      in_exp[i]  = c;
      out_exp[i] = c;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_power(input logic lvl);
    @(negedge clk);
    preset_level = lvl;
    rst_n        = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    set_all(lvl ? HALF_SCALE : ZERO_CODE);
    chk_chans("power-on output code");
    check(CODE_W'(word_ready), CODE_W'(1'b1), "buffer room");
    update();
    chk_chans("power-on input code");
  endtask

  // loads stay hidden until the strobe, then all four move together
  task automatic t_double();
    logic [CODE_W-1:0] codes [NUM_CH];
    codes = '{14'h3FFF, 14'h0001, 14'h1555, 14'h2AAA};
    for (int c = 0; c < NUM_CH; c++) begin
      send(2'(c), codes[c]);
    end
    chk_chans("held before strobe");
    update();
    chk_chans("all channels updated");
  endtask

  // strobe with select low and no sclk activity at all
  task automatic t_async();
    send(2'h2, 14'h0F0F);
    qds_host_i.open_frame();
    update();
    chk_chans("strobe with select low");
    qds_host_i.close_frame();
  endtask

  // 40-bit frame: leading bits drop, chain_out replays the stream
  task automatic t_long();
    qds_host_i.open_frame();
    qds_host_i.shift(64'({24'hC3A5E1, 2'h1, 14'h2468}), 40);
    qds_host_i.close_frame();
    in_exp[1] = 14'h2468;
    update();
    chk_chans("last sixteen bits used");
    // seen_q[k] is chain_out after k pulses, so it holds bit k - 17
    for (int k = CHAIN_DLY; k <= 40; k++) begin
      check(CODE_W'(qds_host_i.seen_q[k]),
            CODE_W'(qds_host_i.bits_q[k - CHAIN_DLY]),
            "chain delay");
    end
  endtask

  // pulses while deselected must not move the shift register
  task automatic t_cs_high();
    logic c;
    c = chain_out;
    qds_host_i.shift(64'h0000_0000_0000_5A5A, WORD_W);
    foreach (qds_host_i.seen_q[k]) begin
      check(CODE_W'(qds_host_i.seen_q[k]), CODE_W'(c), "chain moved");
    end
    qds_host_i.open_frame();
    qds_host_i.close_frame();
    update();
    chk_chans("shift register kept");
  endtask

  // preset beats a concurrent strobe and a frame sent meanwhile
  task automatic t_preset(input logic lvl);
    @(negedge clk);
    preset_level = lvl;
    repeat (3) @(negedge clk);
    preset_n        = 1'b0;
    output_update_n = 1'b0;
    qds_host_i.open_frame();
    qds_host_i.shift(64'h0000_0000_0000_F5A5, WORD_W);
    qds_host_i.close_frame();
    output_update_n = 1'b1;
    preset_n        = 1'b1;
    repeat (4) @(negedge clk);
    set_all(lvl ? HALF_SCALE : ZERO_CODE);
    chk_chans("preset over strobe");
    update();
    chk_chans("input registers preset");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_n           = 1'b0;
    preset_n        = 1'b1;
    preset_level    = 1'b1;
    output_update_n = 1'b1;
    fails           = 0;
    n_checks        = 0;
    t_power(1'b1);
    t_double();
    t_async();
    t_long();
    t_cs_high();
    t_preset(1'b1);
    t_preset(1'b0);
    t_power(1'b0);
    end_sim();
  end

  // run needs about 1600 clk; a hung handshake stops here instead
  initial begin
    #200000;
    fails++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    end_sim();
  end
endmodule  // qds_top_tb
